// ==== pll_clock_gen_registers.sv ====
// PLL control and status registers with base clock source switch
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "pll_regs_cfg.svh"

module pll_clock_gen_registers #(
  parameter int SYNC_CYCLES = `SWITCH_SYNC_CYCLES
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  input  wire logic [2:0]                addr_i,
  input  wire logic [7:0]                wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [7:0]                rdata_o,
  input  wire logic                      oscillator_clock_i,
  input  wire logic                      divided_vco_clock_i,
  input  wire logic                      loop_locked_i,
  input  wire logic                      loop_tracking_i,
  output logic                           base_clock_out_o,
  output logic                           base_select_o,
  output logic                           loop_enable_o,
  output logic                           lock_irq_request_o,
  output pll_regs_pkg::loop_cfg_t        loop_cfg_o
);

  // Four-bit wait counters; a single edge would not prove a source alive
  if (SYNC_CYCLES < 2 || SYNC_CYCLES > 8) begin : g_sync_range
    $error("SYNC_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  pll_regs_pkg::reg_req_t req;
  logic        lock_irq_enable;
  logic        lock_change_flag;
  logic        loop_on;
  logic        base_clock_select;
  logic [1:0]  prescale;
  logic [1:0]  vco_pow2_range;
  logic        auto_mode;
  logic        lock_state;
  logic        acq_shadow;
  logic [11:0] feedback_multiplier;
  logic [7:0]  vco_linear_range;
  logic [3:0]  reference_divide;
  logic        range_zero;
  logic        wr_ctl;
  logic        wr_bw;
  logic        next_loop_on;
  logic        next_select;
  logic        want_on;
  logic        want_sel;
  logic        lock_seen;
  logic        loop_allowed;

  assign req.addr  = addr_i;
  assign req.wdata = wdata_i;
  assign req.wr    = wr_i;
  assign req.rd    = rd_i;

  assign wr_ctl       = req.wr && (req.addr == `OFS_PLL_CONTROL);
  assign wr_bw        = req.wr && (req.addr == `OFS_PLL_BANDWIDTH);
  assign range_zero   = (vco_linear_range == 8'h00);
  assign want_on      = req.wdata[`CTL_LOOP_ON_BIT];
  assign want_sel     = req.wdata[`CTL_BCS_BIT];
  assign loop_allowed = loop_on && !range_zero;

  // ----------------------------------------------------------------
  // Loop on and base select interlock
  // ----------------------------------------------------------------
  always_comb begin
    next_loop_on = loop_on;
    next_select  = base_clock_select;
    // Other control fields still land when this pair is rejected
    if (wr_ctl) begin
      if ((want_on != loop_on) && (want_sel != base_clock_select)) begin
        next_loop_on = loop_on;
        next_select  = base_clock_select;
      end else begin
        if (!(base_clock_select && !want_on)) begin
          next_loop_on = want_on;
        end
        if (!(want_sel && !loop_on)) begin
          next_select = want_sel;
        end
      end
    end
    if (range_zero) begin
      next_select = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      loop_on           <= 1'b1;
      base_clock_select <= 1'b0;
    end else begin
      loop_on           <= next_loop_on;
      base_clock_select <= next_select;
    end
  end

  // ----------------------------------------------------------------
  // Protected configuration fields
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prescale       <= 2'h0;
      vco_pow2_range <= 2'h0;
    end else if (wr_ctl && !loop_on) begin
      prescale       <= req.wdata[`CTL_PRE_HI:`CTL_PRE_LO];
      vco_pow2_range <= req.wdata[`CTL_VPR_HI:`CTL_VPR_LO];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      feedback_multiplier <= `RST_FBMUL;
      vco_linear_range    <= `RST_VCO_RANGE;
      reference_divide    <= `RST_REF_DIVIDE;
    end else if (req.wr && !loop_on) begin
      // high holds bits eleven to eight
      if (req.addr == `OFS_FBMUL_HIGH) begin
        feedback_multiplier[11:8] <= req.wdata[3:0];
      end
      if (req.addr == `OFS_FBMUL_LOW) begin
        feedback_multiplier[7:0] <= req.wdata;
      end
      if (req.addr == `OFS_VCO_RANGE) begin
        vco_linear_range <= req.wdata;
      end
      if (req.addr == `OFS_REF_DIVIDE) begin
        reference_divide <= req.wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bandwidth mode, lock and acquisition
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      auto_mode  <= 1'b0;
      acq_shadow <= 1'b0;
    end else if (wr_bw) begin
      auto_mode <= req.wdata[`BW_AUTO_BIT];
      if (!auto_mode) begin
        acq_shadow <= req.wdata[`BW_ACQ_BIT];
      end
    end
  end

  assign lock_seen = auto_mode && loop_allowed && loop_locked_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lock_state <= 1'b0;
    end else begin
      lock_state <= lock_seen;
    end
  end

  // ----------------------------------------------------------------
  // Lock change flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lock_irq_enable <= 1'b0;
    end else if (!auto_mode) begin
      lock_irq_enable <= 1'b0;
    end else if (wr_ctl) begin
      lock_irq_enable <= req.wdata[`CTL_IRQ_EN_BIT];
    end
  end

  // A lock change in the cycle of a read wins, so no change is lost
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lock_change_flag <= 1'b0;
    end else if (auto_mode && (lock_seen != lock_state)) begin
      // set on lock toggle; set beats clear
      lock_change_flag <= 1'b1;
    end else if (req.rd && (req.addr == `OFS_PLL_CONTROL)) begin
      lock_change_flag <= 1'b0;
    end else if (!auto_mode) begin
      lock_change_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lock_irq_request_o <= 1'b0;
    end else begin
      lock_irq_request_o <= auto_mode && lock_change_flag && lock_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        `OFS_PLL_CONTROL: begin
          rdata_o <= {lock_irq_enable & auto_mode, lock_change_flag & auto_mode,
                      loop_on, base_clock_select, prescale, vco_pow2_range};
        end
        `OFS_PLL_BANDWIDTH: begin
          rdata_o <= {auto_mode, lock_state & auto_mode,
                      auto_mode ? loop_tracking_i : acq_shadow, 5'h00};
        end
        `OFS_FBMUL_HIGH: rdata_o <= {4'h0, feedback_multiplier[11:8]};
        `OFS_FBMUL_LOW:  rdata_o <= feedback_multiplier[7:0];
        `OFS_VCO_RANGE:  rdata_o <= vco_linear_range;
        `OFS_REF_DIVIDE: rdata_o <= {4'h0, reference_divide};
        default:         rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Configuration to the analog loop
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      loop_enable_o <= 1'b0;
      loop_cfg_o    <= '0;
    end else begin
      loop_enable_o                       <= loop_allowed;
      loop_cfg_o.prescale                 <= prescale;
      loop_cfg_o.vco_pow2_range           <= vco_pow2_range;
      loop_cfg_o.feedback_multiplier      <= (feedback_multiplier == 12'h000) ? 12'h001 : feedback_multiplier;
      loop_cfg_o.vco_linear_range         <= vco_linear_range;
      loop_cfg_o.reference_divide         <= (reference_divide == 4'h0) ? 4'h1 : reference_divide;
      loop_cfg_o.acquire_track_select     <= auto_mode ? loop_tracking_i : acq_shadow;
    end
  end

  // ----------------------------------------------------------------
  // Base clock source switch
  // ----------------------------------------------------------------
  // Source clocks are sampled as data; the base clock is a divided
  // level toggled on source rising edges, so it is slow by design.
  logic [2:0] osc_hist;
  logic [2:0] vco_hist;
  logic       osc_rise;
  logic       vco_rise;
  logic       active_sel;
  logic [3:0] osc_cnt;
  logic [3:0] vco_cnt;
  pll_regs_pkg::switch_state_t sw_state;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      osc_hist <= 3'h0;
      vco_hist <= 3'h0;
    end else begin
      osc_hist <= {osc_hist[1:0], oscillator_clock_i};
      vco_hist <= {vco_hist[1:0], divided_vco_clock_i};
    end
  end

  assign osc_rise = osc_hist[1] && !osc_hist[2];
  assign vco_rise = vco_hist[1] && !vco_hist[2];

  // switch waits three cycles of each
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sw_state   <= pll_regs_pkg::SW_STEADY;
      active_sel <= 1'b0;
      osc_cnt    <= 4'h0;
      vco_cnt    <= 4'h0;
    end else begin
      unique case (sw_state)
        pll_regs_pkg::SW_STEADY: begin
          osc_cnt <= 4'h0;
          vco_cnt <= 4'h0;
          if (base_clock_select != active_sel) begin
            sw_state <= pll_regs_pkg::SW_WAIT;
          end
        end
        pll_regs_pkg::SW_WAIT: begin
          if (osc_rise && osc_cnt < 4'(SYNC_CYCLES)) begin
            osc_cnt <= osc_cnt + 4'h1;
          end
          // A VCO stopped by loop off or zero range must not hang the oscillator path
          if ((vco_rise || !loop_allowed) && vco_cnt < 4'(SYNC_CYCLES)) begin
            vco_cnt <= vco_cnt + 4'h1;
          end
          if (osc_cnt == 4'(SYNC_CYCLES) && vco_cnt == 4'(SYNC_CYCLES)) begin
            sw_state <= pll_regs_pkg::SW_TAKE;
          end
        end
        // Takes the select as it stands now, so a change mid-wait settles once
        pll_regs_pkg::SW_TAKE: begin
          active_sel <= base_clock_select;
          sw_state   <= pll_regs_pkg::SW_STEADY;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      base_clock_out_o <= 1'b0;
      base_select_o    <= 1'b0;
    end else begin
      base_select_o <= active_sel;
      if (sw_state == pll_regs_pkg::SW_STEADY && (active_sel ? vco_rise : osc_rise)) begin
        base_clock_out_o <= !base_clock_out_o;
      end
    end
  end

endmodule : pll_clock_gen_registers

// ==== pll_clock_gen_registers_monitor.sv ====
// Port checker of the PLL register block
`timescale 1ns/1ps
module pll_clock_gen_registers_monitor #(
  parameter int SYNC_CYCLES = 3
) (
  input wire logic                    mclk_i,
  input wire logic                    rst_i,
  input wire logic [2:0]              addr_i,
  input wire logic [7:0]              wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [7:0]              rdata_o,
  input wire logic                    oscillator_clock_i,
  input wire logic                    divided_vco_clock_i,
  input wire logic                    loop_locked_i,
  input wire logic                    loop_tracking_i,
  input wire logic                    base_clock_out_o,
  input wire logic                    base_select_o,
  input wire logic                    loop_enable_o,
  input wire logic                    lock_irq_request_o,
  input wire pll_regs_pkg::loop_cfg_t loop_cfg_o
);
  logic auto_q;

  // Auto mode as last written; the bit itself is never protected
  always_ff @(posedge mclk_i) begin
    if (rst_i) auto_q <= 1'b0;
    else if (wr_i && addr_i == 3'h1) auto_q <= wdata_i[7];
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > 3'h5 |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_ctl_manual_zero: assert property (
    $past(rd_i) && $past(addr_i) == 3'h0 && !$past(auto_q) |-> rdata_o[7:6] == 2'b00)
    else $error("enable or flag seen in manual mode");
  chk_lock_manual_zero: assert property (
    $past(rd_i) && $past(addr_i) == 3'h1 && !$past(auto_q) |-> rdata_o[6] == 1'b0)
    else $error("lock seen in manual mode");
  chk_irq_manual: assert property (!auto_q && !$past(auto_q) |-> !lock_irq_request_o)
    else $error("irq in manual mode");
  chk_select_needs_loop: assert property ($rose(base_select_o) |-> loop_enable_o)
    else $error("vco path taken with loop off");
  chk_cfg_locked: assert property (
    loop_enable_o && $past(loop_enable_o) && $past(loop_enable_o, 2)
    |-> $stable({loop_cfg_o.prescale, loop_cfg_o.vco_pow2_range, loop_cfg_o.feedback_multiplier,
                 loop_cfg_o.vco_linear_range, loop_cfg_o.reference_divide}))
    else $error("config moved while loop on");
  chk_cfg_nonzero: assert property (
    !$past(rst_i) |-> loop_cfg_o.feedback_multiplier != 12'h000 && loop_cfg_o.reference_divide != 4'h0)
    else $error("zero multiplier or divider shown");
  chk_loop_on_reset: assert property ($past(rst_i, 3) && !$past(rst_i, 2) |-> loop_enable_o)
    else $error("loop not on after reset");

  cover property ($rose(base_select_o));
  cover property ($fell(base_select_o));
  cover property ($rose(lock_irq_request_o));
endmodule : pll_clock_gen_registers_monitor

// ==== pll_regs_cfg.svh ====
// Register offsets, field positions, reset values and timing counts of the PLL register block
`ifndef PLL_REGS_CFG_SVH
`define PLL_REGS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_PLL_CONTROL     3'h0
`define OFS_PLL_BANDWIDTH   3'h1
`define OFS_FBMUL_HIGH      3'h2
`define OFS_FBMUL_LOW       3'h3
`define OFS_VCO_RANGE       3'h4
`define OFS_REF_DIVIDE      3'h5

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_IRQ_EN_BIT      7
`define CTL_FLAG_BIT        6
`define CTL_LOOP_ON_BIT     5
`define CTL_BCS_BIT         4
`define CTL_PRE_HI          3
`define CTL_PRE_LO          2
`define CTL_VPR_HI          1
`define CTL_VPR_LO          0

// ----------------------------------------------------------------
// Bandwidth register fields
// ----------------------------------------------------------------
`define BW_AUTO_BIT         7
`define BW_LOCK_BIT         6
`define BW_ACQ_BIT          5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_FBMUL           12'h040
`define RST_VCO_RANGE       8'h40
`define RST_REF_DIVIDE      4'h1

// ----------------------------------------------------------------
// Source switch timing, in cycles of each source
// ----------------------------------------------------------------
`define SWITCH_SYNC_CYCLES  3

`endif

// ==== pll_regs_pkg.sv ====
// Types shared by the PLL register block
package pll_regs_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0]  prescale;
    logic [1:0]  vco_pow2_range;
    logic [11:0] feedback_multiplier;
    logic [7:0]  vco_linear_range;
    logic [3:0]  reference_divide;
    logic        acquire_track_select;
  } loop_cfg_t;

  typedef enum logic [2:0] {
    SW_STEADY = 3'b001,
    SW_WAIT   = 3'b010,
    SW_TAKE   = 3'b100
  } switch_state_t;

endpackage : pll_regs_pkg

// ==== tb_top.sv ====
// Self-checking bench of the PLL register block
`timescale 1ns/1ps
module tb_top;
  localparam int OSC_P = 8;
  localparam int VCO_P = 6;
  logic                    mclk_i;
  logic                    rst_i;
  logic [2:0]              addr_i;
  logic [7:0]              wdata_i;
  logic                    wr_i;
  logic                    rd_i;
  logic [7:0]              rdata_o;
  logic                    osc = 1'b0;
  logic                    vco = 1'b0;
  logic                    locked;
  logic                    tracking;
  logic                    base_clock_out_o;
  logic                    base_select_o;
  logic                    loop_enable_o;
  logic                    lock_irq_request_o;
  pll_regs_pkg::loop_cfg_t loop_cfg_o;
  int                      n_errors;
  int                      check_count;
  int                      tick = 0;

  pll_clock_gen_registers pll_clock_gen_registers_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .oscillator_clock_i(osc), .divided_vco_clock_i(vco), .loop_locked_i(locked),
    .loop_tracking_i(tracking), .base_clock_out_o(base_clock_out_o), .base_select_o(base_select_o),
    .loop_enable_o(loop_enable_o), .lock_irq_request_o(lock_irq_request_o), .loop_cfg_o(loop_cfg_o));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Sources far below the bus clock, since the block samples them as data
  always @(posedge mclk_i) begin
    tick <= tick + 1;
    osc  <= (tick % OSC_P) < (OSC_P / 2);
    vco  <= (tick % VCO_P) < (VCO_P / 2);
  end

  task automatic final_report;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd

  // The output must rest through the switch, longer than any normal half period
  task automatic wait_sel(input logic v);
    int   n;
    int   quiet;
    int   longest;
    logic last;
    quiet   = 0;
    longest = 0;
    #1;
    last    = base_clock_out_o;
    for (n = 0; n < 3 * (OSC_P + VCO_P) + 8 && base_select_o !== v; n++) begin
      @(posedge mclk_i);
      #1;
      quiet = (base_clock_out_o === last) ? quiet + 1 : 0;
      if (quiet > longest) longest = quiet;
      last = base_clock_out_o;
    end
    chk(longest >= 2 * OSC_P, 1'b1);
    chk(base_select_o, v);
    if (base_select_o !== v) final_report();
  endtask : wait_sel

  task automatic toggles(input int period);
    int   cnt;
    logic last;
    cnt  = 0;
    last = base_clock_out_o;
    repeat (12 * period) begin
      @(posedge mclk_i);
      #1;
      if (base_clock_out_o !== last) cnt++;
      last = base_clock_out_o;
    end
    chk(cnt >= 11 && cnt <= 13, 1'b1);
  endtask : toggles

  task automatic reset_values;
    rd(3'h0, 8'h20);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h40);
    rd(3'h4, 8'h40);
    rd(3'h5, 8'h01);
    rd(3'h6, 8'h00);
    chk(loop_cfg_o.feedback_multiplier, 12'h040);
  endtask : reset_values

  task automatic protection;
    wr(3'h0, 8'h2F);
    rd(3'h0, 8'h20);
    wr(3'h2, 8'h05);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h40);
    rd(3'h4, 8'h40);
    rd(3'h5, 8'h01);
    wr(3'h0, 8'h00);
    wr(3'h0, 8'h0E);
    rd(3'h0, 8'h0E);
    chk(loop_cfg_o.prescale, 2'h3);
    chk(loop_cfg_o.vco_pow2_range, 2'h2);
    wr(3'h3, 8'h00);
    wr(3'h5, 8'h00);
    rd(3'h3, 8'h00);
    chk(loop_cfg_o.feedback_multiplier, 12'h001);
    chk(loop_cfg_o.reference_divide, 4'h1);
    wr(3'h3, 8'h40);
    wr(3'h0, 8'h1E);
    rd(3'h0, 8'h0E);
    wr(3'h0, 8'h3E);
    rd(3'h0, 8'h0E);
    wr(3'h0, 8'h2E);
    wr(3'h0, 8'h3E);
    wait_sel(1'b1);
    toggles(VCO_P);
    wr(3'h0, 8'h1E);
    rd(3'h0, 8'h3E);
    wr(3'h0, 8'h0E);
    rd(3'h0, 8'h3E);
    wr(3'h0, 8'h2E);
    wait_sel(1'b0);
    toggles(OSC_P);
  endtask : protection

  task automatic range_zero;
    wr(3'h0, 8'h0E);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h2E);
    wr(3'h0, 8'h3E);
    rd(3'h0, 8'h2E);
    chk(loop_enable_o, 1'b0);
    chk(base_select_o, 1'b0);
    wr(3'h0, 8'h0E);
    wr(3'h4, 8'h40);
    wr(3'h0, 8'h2E);
    rd(3'h4, 8'h40);
    chk(loop_cfg_o.vco_linear_range, 8'h40);
    chk(loop_enable_o, 1'b1);
  endtask : range_zero

  task automatic auto_mode;
    int n;
    wr(3'h0, 8'hAE);
    rd(3'h0, 8'h2E);
    wr(3'h1, 8'h20);
    rd(3'h1, 8'h20);
    wr(3'h1, 8'hA0);
    rd(3'h1, 8'h80);
    chk(loop_cfg_o.acquire_track_select, 1'b0);
    @(posedge mclk_i) tracking <= 1'b1;
    rd(3'h1, 8'hA0);
    wr(3'h0, 8'hAE);
    rd(3'h0, 8'hAE);
    @(posedge mclk_i) locked <= 1'b1;
    for (n = 0; n < 20 && lock_irq_request_o !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
    end
    chk(lock_irq_request_o, 1'b1);
    if (n == 20) final_report();
    rd(3'h1, 8'hE0);
    rd(3'h0, 8'hEE);
    rd(3'h0, 8'hAE);
    chk(lock_irq_request_o, 1'b0);
    wr(3'h0, 8'h2E);
    @(posedge mclk_i) locked <= 1'b0;
    repeat (12) @(posedge mclk_i);
    #1;
    chk(lock_irq_request_o, 1'b0);
    rd(3'h0, 8'h6E);
    @(posedge mclk_i) locked <= 1'b1;
    tracking <= 1'b0;
    wr(3'h1, 8'h00);
    rd(3'h1, 8'h20);
    chk(loop_cfg_o.acquire_track_select, 1'b1);
    rd(3'h0, 8'h2E);
  endtask : auto_mode

  initial begin
    rst_i       = 1'b1;
    addr_i      = 3'h0;
    wdata_i     = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    locked      = 1'b0;
    tracking    = 1'b0;
    n_errors    = 0;
    check_count = 0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    reset_values();
    protection();
    range_zero();
    auto_mode();
    final_report();
  end
endmodule : tb_top

bind pll_clock_gen_registers pll_clock_gen_registers_monitor #(.SYNC_CYCLES(SYNC_CYCLES)) monitor_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .oscillator_clock_i(oscillator_clock_i), .divided_vco_clock_i(divided_vco_clock_i),
  .loop_locked_i(loop_locked_i), .loop_tracking_i(loop_tracking_i), .base_clock_out_o(base_clock_out_o),
  .base_select_o(base_select_o), .loop_enable_o(loop_enable_o), .lock_irq_request_o(lock_irq_request_o),
  .loop_cfg_o(loop_cfg_o));
